// ===== design/hims_pkg.sv
// constants and types shared by the host interface mode select block
package hims_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_CLK_KHZ = 25000;
  localparam int SPI_MAX_RATE_MHZ = 50;
  localparam int I2C_STD_RATE_KHZ = 100;
  localparam int I2C_FAST_RATE_KHZ = 400;
  // sys clocks per quarter period of the fastest i2c clock, rounded down
  localparam int I2C_QUARTER_CYCLES = SYS_CLK_KHZ / (I2C_FAST_RATE_KHZ * 4);
  localparam int SYNC_STAGES = 2;
  // cycles after reset release before the strap sampler trusts synced pins
  localparam logic [1:0] STRAP_SETTLE_INIT = 2'h3;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int SPI_WORD_BITS = 24;
  localparam int PAR_UPPER_BITS = 3;
  localparam int PAR_UPPER_LSB = 11;
  localparam logic [2:0] PAR_UPPER_RESET = 3'h0;

  // mode chosen by the shared pins
  typedef enum logic [1:0] {
    MODE_PARALLEL,
    MODE_SPI,
    MODE_I2C
  } hims_mode_t;

  // the four shared interface pins as seen at the package
  typedef struct packed {
    logic serial_parallel_select;
    logic bit_eleven_or_protocol_select;
    logic bit_twelve_or_serial_clock;
    logic bit_thirteen_or_serial_data;
  } hims_pins_t;

  // events seen on the i2c link
  typedef struct packed {
    logic start;
    logic stop;
  } hims_i2c_evt_t;

endpackage

// ===== design/hims_sync.sv
// two flip-flop synchroniser for a group of slow asynchronous levels
module hims_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import hims_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // elaboration check: an empty group cannot be synchronised
  if (WIDTH < 1) begin : g_width_check
    $error("hims_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ===== design/hims_mode_select.sv
// host interface mode select: pin mux, fifo strap, spi shifter and i2c front end
module hims_mode_select #(
  parameter int SPI_BITS = hims_pkg::SPI_WORD_BITS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire hims_pkg::hims_pins_t pins,
  input wire logic write_buffer_enable,
  input wire logic clear_n,
  input wire logic spi_frame_n,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic sda_out,
  output logic sda_oe,
  output hims_pkg::hims_mode_t mode,
  output logic fifo_enable,
  output logic [hims_pkg::PAR_UPPER_BITS-1:0] parallel_upper,
  output logic [SPI_BITS-1:0] spi_word,
  output logic spi_word_valid,
  input wire logic [SPI_BITS-1:0] spi_readback_data,
  input wire logic spi_readback_load,
  output logic i2c_scl,
  output logic i2c_sda,
  output hims_pkg::hims_i2c_evt_t i2c_event,
  input wire logic i2c_pull_low
);
  import hims_pkg::*;

  localparam int CNT_W = $clog2(SPI_BITS + 1);

  // elaboration checks on what the shifter and the i2c sampling can serve
  if (SPI_BITS < 2) begin : g_bits_check
    $error("hims_mode_select: SPI_BITS must be at least 2");
  end
  if (I2C_QUARTER_CYCLES < 1) begin : g_rate_check
    $error("hims_mode_select: sys clock too slow for fast i2c");
  end

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  // asynchronous assert, synchronous release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  hims_pins_t pins_s;
  logic wbe_s;
  logic clear_n_s;
  logic frame_n_s;
  logic [6:0] sync_bus;

  hims_sync #(
    .WIDTH(7)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n_reg),
    .async_in({pins, write_buffer_enable, clear_n, spi_frame_n}),
    .sync_out(sync_bus)
  );

  assign pins_s = sync_bus[6:3];
  assign wbe_s = sync_bus[2];
  assign clear_n_s = sync_bus[1];
  assign frame_n_s = sync_bus[0];

  // ****************************************************************
  // mode decode
  // ****************************************************************
  wire serial_sel = pins_s.serial_parallel_select;
  wire proto_sel = pins_s.bit_eleven_or_protocol_select;
  wire mode_spi = serial_sel && !proto_sel;
  wire mode_i2c = serial_sel && proto_sel;
  wire mode_par = !serial_sel;
  hims_mode_t mode_next;

  assign mode_next = mode_spi ? MODE_SPI : (mode_i2c ? MODE_I2C : MODE_PARALLEL);

  // history of the serial clock, data and clear for edge finding
  logic sclk_d_reg;
  logic sdat_d_reg;
  logic clear_n_d_reg;
  hims_mode_t mode_reg;

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sclk_d_reg <= 1'b0;
      sdat_d_reg <= 1'b1;
      clear_n_d_reg <= 1'b0; // matches the synced copy in reset, so no false clear edge
      mode_reg <= MODE_PARALLEL;
    end else begin
      sclk_d_reg <= pins_s.bit_twelve_or_serial_clock;
      sdat_d_reg <= pins_s.bit_thirteen_or_serial_data;
      clear_n_d_reg <= clear_n_s;
      mode_reg <= mode_next;
    end
  end

  wire sclk_now = pins_s.bit_twelve_or_serial_clock;
  wire sdat_now = pins_s.bit_thirteen_or_serial_data;
  wire sclk_fall = sclk_d_reg && !sclk_now;
  wire sclk_rise = !sclk_d_reg && sclk_now;
  wire clear_fall = clear_n_d_reg && !clear_n_s;

  assign mode = mode_reg;

  // ****************************************************************
  // write fifo strap
  // ****************************************************************
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  logic strap_reg;
  logic strap_next;
  logic fifo_en_reg;

  // sample once after reset settles and again on each clear falling edge
  wire strap_sample = (settle_reg == 2'h1) || clear_fall;

  assign settle_next = (settle_reg != 2'h0) ? settle_reg - 2'h1 : 2'h0;
  assign strap_next = strap_sample ? wbe_s : strap_reg;

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      settle_reg <= STRAP_SETTLE_INIT;
      strap_reg <= 1'b0;
      fifo_en_reg <= 1'b0;
    end else begin
      settle_reg <= settle_next;
      strap_reg <= strap_next;
      fifo_en_reg <= strap_reg && mode_par;
    end
  end

  assign fifo_enable = fifo_en_reg;

  // ****************************************************************
  // parallel upper bits
  // ****************************************************************
  logic [PAR_UPPER_BITS-1:0] par_upper_reg;
  wire [PAR_UPPER_BITS-1:0] par_upper_pins = {pins_s.bit_thirteen_or_serial_data,
                                              pins_s.bit_twelve_or_serial_clock,
                                              pins_s.bit_eleven_or_protocol_select};

  // pins carry bits 11 to 13 only while parallel mode holds
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      par_upper_reg <= PAR_UPPER_RESET;
    end else if (mode_par) begin
      par_upper_reg <= par_upper_pins;
    end
  end

  assign parallel_upper = par_upper_reg;

  // ****************************************************************
  // spi shifter
  // ****************************************************************
  logic [SPI_BITS-1:0] shift_in_reg;
  logic [SPI_BITS-1:0] shift_out_reg;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [SPI_BITS-1:0] word_reg;
  logic word_valid_reg;
  logic sdo_reg;

  wire spi_active = (mode_reg == MODE_SPI) && !frame_n_s;
  wire spi_take = spi_active && sclk_fall;
  wire spi_give = spi_active && sclk_rise;
  wire word_done = spi_take && (bit_cnt_reg == CNT_W'(SPI_BITS - 1));
  wire [SPI_BITS-1:0] shift_in_next = {shift_in_reg[SPI_BITS-2:0], sdat_now};
  wire [CNT_W-1:0] bit_cnt_next = !spi_active ? '0 :
                                  (word_done ? '0 : (spi_take ? bit_cnt_reg + 1'b1 : bit_cnt_reg));

  // input shift on falling edges, word handed on after the last bit
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shift_in_reg <= '0;
      bit_cnt_reg <= '0;
      word_reg <= '0;
      word_valid_reg <= 1'b0;
    end else begin
      shift_in_reg <= spi_take ? shift_in_next : shift_in_reg;
      bit_cnt_reg <= bit_cnt_next;
      word_reg <= word_done ? shift_in_next : word_reg;
      word_valid_reg <= word_done;
    end
  end

  // readback shift on rising edges, msb first
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shift_out_reg <= '0;
      sdo_reg <= 1'b0;
    end else if (spi_readback_load) begin
      shift_out_reg <= spi_readback_data;
    end else if (spi_give) begin
      sdo_reg <= shift_out_reg[SPI_BITS-1];
      shift_out_reg <= {shift_out_reg[SPI_BITS-2:0], 1'b0};
    end
  end

  assign spi_word = word_reg;
  assign spi_word_valid = word_valid_reg;
  assign serial_data_out = sdo_reg;
  assign serial_data_oe = spi_active;

  // ****************************************************************
  // i2c front end
  // ****************************************************************
  logic scl_reg;
  logic sda_reg;
  hims_i2c_evt_t evt_reg;
  hims_i2c_evt_t evt_next;
  logic pull_reg;

  wire i2c_on = (mode_reg == MODE_I2C);
  // start and stop are data edges while the clock stays high
  wire evt_start = i2c_on && sclk_now && sclk_d_reg && sdat_d_reg && !sdat_now;
  wire evt_stop = i2c_on && sclk_now && sclk_d_reg && !sdat_d_reg && sdat_now;

  assign evt_next = {evt_start, evt_stop};

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      evt_reg <= '0;
      pull_reg <= 1'b0;
    end else begin
      scl_reg <= i2c_on ? sclk_now : 1'b1;
      sda_reg <= i2c_on ? sdat_now : 1'b1;
      evt_reg <= evt_next;
      pull_reg <= i2c_on && i2c_pull_low;
    end
  end

  assign i2c_scl = scl_reg;
  assign i2c_sda = sda_reg;
  assign i2c_event = evt_reg;
  // open drain: the data level is low whenever driven
  assign sda_out = 1'b0;
  assign sda_oe = pull_reg;

endmodule

// ===== verif/hims_mode_select_props.sv
// checker of the mode select block's port behaviour
module hims_mode_select_props #(
  parameter int SPI_BITS = 24
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire hims_pkg::hims_pins_t pins,
  input wire logic i2c_pull_low,
  input wire hims_pkg::hims_mode_t mode,
  input wire logic fifo_enable,
  input wire logic [hims_pkg::PAR_UPPER_BITS-1:0] parallel_upper,
  input wire logic [SPI_BITS-1:0] spi_word,
  input wire logic spi_word_valid,
  input wire logic serial_data_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire hims_pkg::hims_i2c_evt_t i2c_event
);
  timeunit 1ns;
  timeprecision 100ps;
  import hims_pkg::*;
  // ********
  // properties
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_fifo_par;
    mode != MODE_PARALLEL && $past(mode) != MODE_PARALLEL |-> !fifo_enable;
  endproperty
  a_fifo_par: assert property (p_fifo_par) else $error("fifo on in serial mode");
  property p_par_bits;
    mode == MODE_PARALLEL |-> parallel_upper == $past({pins.bit_thirteen_or_serial_data,
      pins.bit_twelve_or_serial_clock, pins.bit_eleven_or_protocol_select}, 3);
  endproperty
  a_par_bits: assert property (p_par_bits) else $error("upper bits wrong");
  property p_par_hold;
    mode != MODE_PARALLEL && $past(mode) != MODE_PARALLEL |-> $stable(parallel_upper);
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("upper bits moved in serial");
  property p_valid_pulse;
    spi_word_valid |=> !spi_word_valid [*8];
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
  property p_word_valid;
    $changed(spi_word) |-> spi_word_valid;
  endproperty
  a_word_valid: assert property (p_word_valid) else $error("word moved without valid");
  property p_sdo_oe;
    serial_data_oe |-> mode == MODE_SPI;
  endproperty
  a_sdo_oe: assert property (p_sdo_oe) else $error("readback driven outside spi");
  property p_start;
    mode == MODE_I2C && pins.bit_twelve_or_serial_clock && $fell(pins.bit_thirteen_or_serial_data)
      |-> ##3 i2c_event.start;
  endproperty
  a_start: assert property (p_start) else $error("start not flagged");
  property p_oe_follow;
    mode == MODE_I2C && $past(mode) == MODE_I2C |-> sda_oe == $past(i2c_pull_low) && !sda_out;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("data line drive wrong");
endmodule
bind hims_mode_select hims_mode_select_props #(.SPI_BITS(SPI_BITS)) i_props (.sys_clk(sys_clk),
  .resetn(resetn), .pins(pins), .i2c_pull_low(i2c_pull_low), .mode(mode), .fifo_enable(fifo_enable),
  .parallel_upper(parallel_upper), .spi_word(spi_word), .spi_word_valid(spi_word_valid),
  .serial_data_oe(serial_data_oe), .sda_out(sda_out), .sda_oe(sda_oe), .i2c_event(i2c_event));

// ===== verif/hims_host_model.sv
// host controller model driving the four shared pins
module hims_host_model (
  input wire logic sys_clk,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic sda_oe,
  output hims_pkg::hims_pins_t pins,
  output logic spi_frame_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import hims_pkg::*;
  logic h_sel = 1'b0, h_proto = 1'b0, h_clk = 1'b0, h_dat = 1'b0;
  initial spi_frame_n = 1'b1;
  // data wire is pulled up and pulled low by either party
  assign pins = {h_sel, h_proto, h_clk, h_dat & ~sda_oe};
  // mode pins change only between transfers
  task automatic set_pins(input logic [3:0] v);
    @(posedge sys_clk);
    {h_sel, h_proto, h_clk, h_dat} <= v;
  endtask
  // top n bits of w, msb first, 320 ns serial clock
  task automatic spi_xfer(input logic [23:0] w, input int n, output logic [23:0] rb);
    rb = 24'h00_0000;
    @(posedge sys_clk) spi_frame_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = 23; i > 23 - n; i--) begin
      h_clk <= 1'b1;
      h_dat <= w[i];
      repeat (4) @(posedge sys_clk);
      // an undriven readback line shows the wrong level
      rb = {rb[22:0], serial_data_oe ? serial_data_out : !serial_data_out};
      h_clk <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    spi_frame_n <= 1'b1;
    h_dat <= ~h_dat; // released line shows junk
  endtask
  // start then stop, q cycles a quarter period
  task automatic i2c_frame(input int q);
    @(posedge sys_clk) h_dat <= 1'b0;
    repeat (q) @(posedge sys_clk);
    h_clk <= 1'b0;
    repeat (q) @(posedge sys_clk);
    h_clk <= 1'b1;
    repeat (q) @(posedge sys_clk);
    h_dat <= 1'b1;
    repeat (q) @(posedge sys_clk);
  endtask
endmodule

// ===== verif/hims_mode_select_tb_top.sv
// self-checking testbench of the host interface mode select block
module hims_mode_select_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hims_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, wbe = 1'b1, clear_n = 1'b1, rb_load = 1'b0, pull_low = 1'b0;
  logic [23:0] rb_data = 24'h00_0000;
  logic spi_frame_n, sdo, sdo_oe, sda_out, sda_oe, fifo_enable, valid, scl, sda;
  logic [2:0] par_up;
  logic [23:0] word, rb;
  hims_pins_t pins;
  hims_mode_t mode;
  hims_i2c_evt_t evt;
  int err_count = 0, total_checks = 0, n_valid = 0, n_start = 0, n_stop = 0, cycles = 0;
  // ********
  // instances, clock, counters
  // ********
  hims_mode_select i_dut (.sys_clk(sys_clk), .resetn(resetn), .pins(pins), .write_buffer_enable(wbe),
    .clear_n(clear_n), .spi_frame_n(spi_frame_n), .serial_data_out(sdo), .serial_data_oe(sdo_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .mode(mode), .fifo_enable(fifo_enable), .parallel_upper(par_up),
    .spi_word(word), .spi_word_valid(valid), .spi_readback_data(rb_data), .spi_readback_load(rb_load),
    .i2c_scl(scl), .i2c_sda(sda), .i2c_event(evt), .i2c_pull_low(pull_low));
  hims_host_model i_host (.sys_clk(sys_clk), .serial_data_out(sdo), .serial_data_oe(sdo_oe), .sda_oe(sda_oe),
    .pins(pins), .spi_frame_n(spi_frame_n));
  initial forever #20 sys_clk = ~sys_clk;
  // pulse counters and the hang limit
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    n_valid <= n_valid + int'(valid === 1'b1);
    n_start <= n_start + int'(evt.start === 1'b1);
    n_stop <= n_stop + int'(evt.stop === 1'b1);
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic pulse_clear();
    @(posedge sys_clk) clear_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    clear_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_parallel();
    check(fifo_enable, 1);
    for (int v = 0; v < 8; v++) begin
      i_host.set_pins({1'b0, v[0], v[1], v[2]});
      repeat (4) @(posedge sys_clk);
      check({mode, par_up}, {MODE_PARALLEL, v[2:0]});
    end
    $display("test parallel done");
  endtask
  task automatic t_clear();
    wbe <= 1'b0;
    pulse_clear();
    check(fifo_enable, 0);
    wbe <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(fifo_enable, 0);
    pulse_clear();
    check(fifo_enable, 1);
    wbe <= 1'b0;
    $display("test clear done");
  endtask
  task automatic t_spi();
    i_host.set_pins(4'h8);
    repeat (6) @(posedge sys_clk);
    check({mode, fifo_enable, sdo_oe}, {MODE_SPI, 2'b00});
    i_host.spi_xfer(24'hff_ffff, 5, rb);
    repeat (4) @(posedge sys_clk);
    rb_data <= 24'ha5_3c96;
    rb_load <= 1'b1;
    @(posedge sys_clk) rb_load <= 1'b0;
    i_host.spi_xfer(24'h5a_c3e1, 24, rb);
    repeat (4) @(posedge sys_clk);
    check(word, 24'h5a_c3e1);
    check(rb, 24'ha5_3c96);
    i_host.spi_xfer(24'h81_0e7f, 24, rb);
    repeat (4) @(posedge sys_clk);
    check({word, 8'(n_valid)}, {24'h81_0e7f, 8'h02});
    $display("test spi done");
  endtask
  task automatic t_i2c();
    int q[2] = '{I2C_QUARTER_CYCLES, SYS_CLK_KHZ / (I2C_STD_RATE_KHZ * 4)};
    i_host.set_pins(4'hf);
    repeat (6) @(posedge sys_clk);
    check({mode, scl, sda}, {MODE_I2C, 2'b11});
    for (int i = 0; i < 2; i++) begin
      i_host.i2c_frame(q[i]);
      repeat (6) @(posedge sys_clk);
      check(n_start, i + 1);
      check(n_stop, i + 1);
    end
    i_host.set_pins(4'hd);
    repeat (4) @(posedge sys_clk);
    pull_low <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check({sda_oe, sda_out, sda}, 3'h4);
    pull_low <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check({sda_oe, sda, scl}, 3'h2);
    $display("test i2c done");
  endtask
  task automatic t_reset();
    i_host.set_pins(4'h0);
    repeat (6) @(posedge sys_clk);
    check({mode, fifo_enable}, {MODE_PARALLEL, 1'b1});
    resetn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (12) @(posedge sys_clk);
    check({fifo_enable, par_up}, 4'h0);
    $display("test reset done");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (12) @(posedge sys_clk);
    t_parallel();
    t_clear();
    t_spi();
    t_i2c();
    t_reset();
    stop_test();
  end
endmodule
